// >>> design/dcs_arbiter.sv
// Behaviour
// RULE_01: select tag with matching logical address raises that channel's compare.
// RULE_02: compare returns unit selected; if allowed, selected flop enables port.
// RULE_03: compare rising starts 300 ns pulse; its end sets reserved flop.
// RULE_04: refuse when other channel holds selected/reserved, or channel disabled.
// RULE_05: selected flops update on alternate 5 MHz phases, never together.
// RULE_06: dropping select tag clears compare, selected flop, port, unit selected.
// RULE_07: after deselect, reservation stays; same channel reselects, other blocked.
// RULE_08: blocked request sets no flops but returns unit selected with busy; the code sets the tried flop (tried_q).
// RULE_09: refusal sets tried flag; on freeing, seek end low 30 us.
// RULE_10: disabled channel gets no response at all to a select.
// RULE_11: selected clear starts 500 ms timer; timeout mode then clears reserve.
// RULE_12: absolute mode keeps reserve at timer expiry.
// RULE_13: control tag with bit 9 clears own reserve and other's disable.
// RULE_14: other channel admitted only once issuer's selected flop is clear.
// RULE_15: both maintenance switches of a channel set disable it.
// RULE_16: priority select disables holder, then selects and reserves requester.
// RULE_17: controller asks priority with select tag, address and bit 9.
// RULE_18: disable flop stays set until the other controller clears it.
// RULE_19: one-shots are counters; synchronous reset gives idle, unreserved state.
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module dcs_arbiter #(
   parameter int unsigned TRIED_CYC = dcs_pkg::TRIED_CYC,
   parameter int unsigned RELEASE_CYC = dcs_pkg::RELEASE_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [dcs_pkg::AVS_AW-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire dcs_pkg::dcs_chan_in_t [1:0] i_chan,
   output dcs_pkg::dcs_chan_out_t [1:0] o_chan,
   output logic o_irq
);

   localparam int RP_W = $clog2(dcs_pkg::RES_PULSE_CYC + 1);
   localparam int TR_W = $clog2(TRIED_CYC + 1);
   localparam int RL_W = $clog2(RELEASE_CYC + 1);
   localparam int DV_W = $clog2(dcs_pkg::OSC_HALF_CYC + 1);

   logic [dcs_pkg::CTRL_W-1:0] ctrl_q;
   logic [dcs_pkg::IRQ_W-1:0] irq_st_q;
   logic [dcs_pkg::IRQ_W-1:0] irq_en_q;
   logic [dcs_pkg::IRQ_W-1:0] irq_ev;
   logic [dcs_pkg::IRQ_W-1:0] irq_clr;
   logic [31:0] rd_data;
   logic [31:0] status_w;
   logic [dcs_pkg::LADDR_W-1:0] cfg_laddr;
   logic abs_mode;
   logic [1:0] sw [2];
   logic [DV_W-1:0] div_q;
   logic tick;
   logic phase_q;
   logic [1:0] cmp, cmp_q, disabled, hold, prio, allow, refuse, relcmd;
   logic [1:0] tick_c, rp_end, rel_end, se_load, sw_off;
   logic [1:0] sel_q, sel_p_q, res_q, dis_q, tried_q;
   logic [RP_W-1:0] rp_cnt_q [2];
   logic [RL_W-1:0] rel_cnt_q [2];
   logic [TR_W-1:0] se_cnt_q [2];
   logic wr_acc;

   // ***********************************************
   // configuration
   // ***********************************************
   assign cfg_laddr = ctrl_q[dcs_pkg::CTRL_LADDR_LSB +: dcs_pkg::LADDR_W];
   assign abs_mode = ctrl_q[dcs_pkg::CTRL_ABS_BIT];
   assign sw[0] = ctrl_q[dcs_pkg::CTRL_SW0_LSB +: 2];
   assign sw[1] = ctrl_q[dcs_pkg::CTRL_SW1_LSB +: 2];

   // ***********************************************
   // oscillator phases
   // ***********************************************
   // 5 MHz half period as enable; phase picks the channel
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         div_q <= '0;
         phase_q <= 1'b0;
      end else if (tick) begin
         div_q <= '0;
         phase_q <= ~phase_q; // see RULE_05
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = (div_q == DV_W'(dcs_pkg::OSC_HALF_CYC - 1));

   // ***********************************************
   // per-channel decisions
   // ***********************************************
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         cmp[c] = i_chan[c].sel_tag &&
            (i_chan[c].laddr == cfg_laddr); // see RULE_01
         sw_off[c] = (sw[c] == 2'b11); // see RULE_15
         disabled[c] = dis_q[c] || sw_off[c]; // see RULE_10
         hold[c] = sel_q[c] || res_q[c];
         // priority request: tag, address and bit 9 together
         prio[c] = cmp[c] && i_chan[c].bus_out9 && !disabled[c] &&
            hold[1-c]; // see RULE_17
         // other's selected flop must clear first, even after release
         allow[c] = cmp[c] && !disabled[c] && !sel_q[1-c] &&
            (!res_q[1-c] || i_chan[c].bus_out9); // see RULE_04 RULE_14
         refuse[c] = cmp[c] && !disabled[c] && !sel_q[c] && hold[1-c] &&
            !i_chan[c].bus_out9; // see RULE_08
         relcmd[c] = i_chan[c].ctl_tag && i_chan[c].bus_out9 &&
            !disabled[c] && hold[c]; // see RULE_13
         tick_c[c] = tick && (phase_q == c[0]);
         rp_end[c] = (rp_cnt_q[c] == RP_W'(1));
         rel_end[c] = (rel_cnt_q[c] == RL_W'(1));
         se_load[c] = tried_q[c] && !hold[1-c];
      end
   end

   // ***********************************************
   // selected, reserved, disable, tried flops
   // ***********************************************
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sel_q <= '0; // see RULE_19
         sel_p_q <= '0;
         cmp_q <= '0;
      end else begin
         sel_p_q <= sel_q;
         cmp_q <= cmp;
         for (int c = 0; c < 2; c++) begin
            if (disabled[c]) begin
               sel_q[c] <= 1'b0; // see RULE_16
            end else if (tick_c[c]) begin
               sel_q[c] <= allow[c]; // see RULE_02 RULE_05 RULE_06
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         res_q <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (dis_q[c] || relcmd[c]) begin
               res_q[c] <= 1'b0; // see RULE_13 RULE_16
            end else if (rel_end[c] && !abs_mode) begin
               res_q[c] <= 1'b0; // see RULE_11 RULE_12
            end else if (rp_end[c] && sel_q[c]) begin
               res_q[c] <= 1'b1; // see RULE_03
            end
            // otherwise held across deselect, see RULE_07
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         dis_q <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (prio[1-c]) begin
               dis_q[c] <= 1'b1; // see RULE_16
            end else if (relcmd[1-c]) begin
               dis_q[c] <= 1'b0; // see RULE_13 RULE_18
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tried_q <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (refuse[c]) begin
               tried_q[c] <= 1'b1; // see RULE_09
            end else if (!hold[1-c]) begin
               tried_q[c] <= 1'b0;
            end
         end
      end
   end

   // ***********************************************
   // one-shot counters
   // ***********************************************
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int c = 0; c < 2; c++) begin
            rp_cnt_q[c] <= '0;
            rel_cnt_q[c] <= '0;
            se_cnt_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (cmp[c] && !cmp_q[c]) begin
               rp_cnt_q[c] <= RP_W'(dcs_pkg::RES_PULSE_CYC); // see RULE_03
            end else if (rp_cnt_q[c] != '0) begin
               rp_cnt_q[c] <= rp_cnt_q[c] - 1'b1;
            end
            if (sel_q[c]) begin
               rel_cnt_q[c] <= '0;
            end else if (sel_p_q[c]) begin
               rel_cnt_q[c] <= RL_W'(RELEASE_CYC); // see RULE_11
            end else if (rel_cnt_q[c] != '0) begin
               rel_cnt_q[c] <= rel_cnt_q[c] - 1'b1;
            end
            if (se_load[c]) begin
               se_cnt_q[c] <= TR_W'(TRIED_CYC); // see RULE_09
            end else if (se_cnt_q[c] != '0) begin
               se_cnt_q[c] <= se_cnt_q[c] - 1'b1;
            end
         end
      end
   end

   // ***********************************************
   // channel outputs
   // ***********************************************
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int c = 0; c < 2; c++) begin
            o_chan[c] <= '{1'b0, 1'b0, 1'b1, 1'b0};
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            o_chan[c].unit_selected <= cmp[c] && !disabled[c]; // see RULE_10
            o_chan[c].busy <= refuse[c]; // see RULE_08
            o_chan[c].seek_end_n <= (se_cnt_q[c] == '0); // see RULE_09
            o_chan[c].port_enable <= sel_q[c]; // see RULE_02
         end
      end
   end

   // ***********************************************
   // interrupts
   // ***********************************************
   always_comb begin
      irq_ev = '0;
      irq_ev[dcs_pkg::IRQ_GRANT_LSB +: 2] = sel_q & ~sel_p_q;
      irq_ev[dcs_pkg::IRQ_REFUSE_LSB +: 2] = refuse & ~tried_q;
      for (int c = 0; c < 2; c++) begin
         irq_ev[dcs_pkg::IRQ_FREE_LSB + c] = rel_end[c] && !abs_mode &&
            res_q[c];
      end
   end

   assign wr_acc = i_avs_write && !o_avs_waitrequest;
   assign irq_clr = (wr_acc && i_avs_address == dcs_pkg::REG_IRQ_CLEAR) ?
      i_avs_writedata[dcs_pkg::IRQ_W-1:0] : '0;

   // set wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_st_q <= '0;
         o_irq <= 1'b0;
      end else begin
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
         o_irq <= |(irq_st_q & irq_en_q);
      end
   end

   // ***********************************************
   // avalon slave
   // ***********************************************
   always_comb begin
      status_w = '0;
      status_w[dcs_pkg::STAT_SEL_LSB +: 2] = sel_q;
      status_w[dcs_pkg::STAT_RES_LSB +: 2] = res_q;
      status_w[dcs_pkg::STAT_DIS_LSB +: 2] = dis_q;
      status_w[dcs_pkg::STAT_TRIED_LSB +: 2] = tried_q;
      status_w[dcs_pkg::STAT_OFF_LSB +: 2] = sw_off;
   end

   always_comb begin
      rd_data = '0;
      if (i_avs_address == dcs_pkg::REG_CTRL) begin
         rd_data = 32'(ctrl_q);
      end else if (i_avs_address == dcs_pkg::REG_STATUS) begin
         rd_data = status_w;
      end else if (i_avs_address == dcs_pkg::REG_IRQ_STATUS) begin
         rd_data = 32'(irq_st_q);
      end else if (i_avs_address == dcs_pkg::REG_IRQ_ENABLE) begin
         rd_data = 32'(irq_en_q);
      end
   end

   // one wait cycle, then accept
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= '0;
      end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata <= i_avs_read ? rd_data : 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_q <= dcs_pkg::CTRL_RST;
         irq_en_q <= dcs_pkg::IRQ_EN_RST;
      end else if (wr_acc) begin
         if (i_avs_address == dcs_pkg::REG_CTRL) begin
            ctrl_q <= i_avs_writedata[dcs_pkg::CTRL_W-1:0] & dcs_pkg::CTRL_MASK;
         end else if (i_avs_address == dcs_pkg::REG_IRQ_ENABLE) begin
            irq_en_q <= i_avs_writedata[dcs_pkg::IRQ_W-1:0];
         end
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   chk_one_selected: assert property ( // see RULE_05
      !(sel_q[0] && sel_q[1]))
      else $error("both channels selected");

   for (genvar g = 0; g < 2; g++) begin : g_chk
      chk_sel_needs_cmp: assert property ( // see RULE_01
         $rose(sel_q[g]) |-> $past(cmp[g]))
         else $error("selected without address match");
      chk_unit_sel_out: assert property ( // see RULE_02
         (cmp[g] && !disabled[g]) |=> o_chan[g].unit_selected)
         else $error("unit selected missing");
      chk_res_on_pulse: assert property ( // see RULE_03
         $rose(res_q[g]) |-> $past(rp_cnt_q[g]) == RP_W'(1))
         else $error("reserve set outside pulse end");
      chk_refuse_blocks: assert property ( // see RULE_04
         (hold[1-g] && !i_chan[g].bus_out9 && !sel_q[g]) |=> !sel_q[g])
         else $error("selected while other holds");
      chk_deselect_tick: assert property ( // see RULE_06
         (tick_c[g] && !cmp[g]) |=> !sel_q[g] && !o_chan[g].unit_selected)
         else $error("selection kept after tag drop");
      chk_busy_refused: assert property ( // see RULE_08
         refuse[g] |=> o_chan[g].busy && o_chan[g].unit_selected &&
            !sel_q[g])
         else $error("refusal not reported");
      chk_seek_end_cause: assert property ( // see RULE_09
         $fell(o_chan[g].seek_end_n) |-> $past(tried_q[g], 2) &&
            !$past(tried_q[g]))
         else $error("seek end pulse without tried clear");
      chk_disabled_mute: assert property ( // see RULE_10 RULE_15
         disabled[g] |=> !o_chan[g].unit_selected && !o_chan[g].busy)
         else $error("disabled channel answered");
      chk_timeout_free: assert property ( // see RULE_11
         (rel_end[g] && !abs_mode && res_q[g]) |=> !res_q[g])
         else $error("timeout did not free reserve");
      chk_abs_holds: assert property ( // see RULE_12
         (rel_end[g] && abs_mode && res_q[g] && !dis_q[g] && !relcmd[g])
            |=> res_q[g])
         else $error("absolute reserve lost at timeout");
      chk_release_cmd: assert property ( // see RULE_13
         (relcmd[g] && !prio[g]) |=> !res_q[g] && !dis_q[1-g])
         else $error("release command ignored");
      chk_prio_takes: assert property ( // see RULE_16
         prio[g] |=> dis_q[1-g] ##1 !sel_q[1-g] && !res_q[1-g])
         else $error("priority select did not disable holder");
      chk_disable_sticky: assert property ( // see RULE_18
         (dis_q[g] && !relcmd[1-g]) |=> dis_q[g])
         else $error("disable flop dropped on its own");
      cov_grant: cover property ($rose(sel_q[g]) ##[1:100] $rose(res_q[g]));
      cov_refuse: cover property (refuse[g]);
      cov_seek_end: cover property ($fell(o_chan[g].seek_end_n));
      cov_prio: cover property (prio[g]);
   end

endmodule

`default_nettype wire

// >>> design/dcs_pkg.sv
package dcs_pkg;

   // ***********************************************
   // clock and timing
   // ***********************************************
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned OSC_KHZ = 5000;
   localparam int unsigned OSC_HALF_CYC = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
   localparam int unsigned RES_PULSE_NS = 300;
   localparam int unsigned RES_PULSE_CYC = (RES_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TRIED_US = 30;
   localparam int unsigned TRIED_CYC = TRIED_US * CLK_MHZ;
   localparam int unsigned RELEASE_MS = 500;
   localparam int unsigned RELEASE_CYC = RELEASE_MS * 1000 * CLK_MHZ;

   // ***********************************************
   // register map (byte addresses)
   // ***********************************************
   localparam int unsigned AVS_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;

   // ***********************************************
   // control fields
   // ***********************************************
   localparam int unsigned LADDR_W = 4;
   localparam int unsigned CTRL_W = 12;
   localparam int unsigned CTRL_LADDR_LSB = 0;
   localparam int unsigned CTRL_ABS_BIT = 4;
   localparam int unsigned CTRL_SW0_LSB = 8;
   localparam int unsigned CTRL_SW1_LSB = 10;
   localparam logic [11:0] CTRL_MASK = 12'hF1F;
   localparam logic [11:0] CTRL_RST = 12'h000;

   // ***********************************************
   // status and interrupt fields
   // ***********************************************
   localparam int unsigned STAT_SEL_LSB = 0;
   localparam int unsigned STAT_RES_LSB = 2;
   localparam int unsigned STAT_DIS_LSB = 4;
   localparam int unsigned STAT_TRIED_LSB = 6;
   localparam int unsigned STAT_OFF_LSB = 8;
   localparam int unsigned IRQ_W = 6;
   localparam int unsigned IRQ_GRANT_LSB = 0;
   localparam int unsigned IRQ_REFUSE_LSB = 2;
   localparam int unsigned IRQ_FREE_LSB = 4;
   localparam logic [5:0] IRQ_EN_RST = 6'h00;

   // ***********************************************
   // channel carriers
   // ***********************************************
   typedef struct packed {
      logic sel_tag;
      logic ctl_tag;
      logic bus_out9;
      logic [LADDR_W-1:0] laddr;
   } dcs_chan_in_t;

   typedef struct packed {
      logic unit_selected;
      logic busy;
      logic seek_end_n;
      logic port_enable;
   } dcs_chan_out_t;

endpackage

// >>> testbench/dcs_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module dcs_ctrl_model (
   input wire logic i_clk,
   output var dcs_pkg::dcs_chan_in_t o_req
);
   initial begin
      o_req = '0;
   end

   // unit select tag with address, priority when prio set
   task automatic sel(input logic [3:0] addr, input logic prio);
      @(posedge i_clk);
      o_req.sel_tag <= 1'b1;
      o_req.laddr <= addr;
      o_req.bus_out9 <= prio;
   endtask

   // address lines no longer held after the tag drops
   task automatic drop();
      @(posedge i_clk);
      o_req.sel_tag <= 1'b0;
      o_req.bus_out9 <= 1'b0;
      o_req.laddr <= ~o_req.laddr;
   endtask

   task automatic rel();
      @(posedge i_clk);
      o_req.ctl_tag <= 1'b1;
      o_req.bus_out9 <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_req.ctl_tag <= 1'b0;
      o_req.bus_out9 <= 1'b0;
   endtask
endmodule

`default_nettype wire

// >>> testbench/dual_channel_select_reserve_tb.sv
`timescale 1ns/1ns
`default_nettype none

module dual_channel_select_reserve_tb;
   localparam int TRIED = 20;
   localparam int RELEASE = 200;
   logic i_clk;
   logic i_reset;
   logic [7:0] adr;
   logic rd;
   logic wr;
   logic [31:0] wd;
   logic [31:0] rdata;
   logic wait_rq;
   logic irq;
   dcs_pkg::dcs_chan_in_t req0;
   dcs_pkg::dcs_chan_in_t req1;
   dcs_pkg::dcs_chan_out_t [1:0] rsp;
   int error_cnt = 0;
   int checks_done = 0;

   dcs_arbiter #(.TRIED_CYC(TRIED), .RELEASE_CYC(RELEASE)) dut_u (
      .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
      .i_chan({req1, req0}), .o_chan(rsp), .o_irq(irq));
   dcs_ctrl_model c0_u (.i_clk(i_clk), .o_req(req0));
   dcs_ctrl_model c1_u (.i_clk(i_clk), .o_req(req1));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   always @(negedge i_clk) begin
      if (rsp[0].port_enable && rsp[1].port_enable) begin
         error_cnt++;
         $display("ERROR t=%0t both channels enabled", $time);
      end
   end

   // ***********************************************
   // shared tasks
   // ***********************************************
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // one Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      logic hold;
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      hold = 1'b1;
      q = 32'h0000_0000;
      // waitrequest and read data sampled at the rising edge itself
      for (int n = 0; n < 20 && hold; n++) begin
         @(posedge i_clk);
         hold = wait_rq;
         q = rdata;
      end
      rd <= 1'b0;
      wr <= 1'b0;
      if (hold) begin
         error_cnt++;
         $display("ERROR t=%0t bus timeout", $time);
         close_out();
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask

   task automatic rstat(input logic [31:0] m, input logic [31:0] e);
      rchk(dcs_pkg::REG_STATUS, m, e);
   endtask

   task automatic seek_pulse(input int bound);
      int n = 0;
      int low = 0;
      while (rsp[1].seek_end_n !== 1'b0 && n < bound) begin
         cyc(1);
         n++;
      end
      if (n >= bound) begin
         error_cnt++;
         $display("ERROR t=%0t seek end pulse timeout", $time);
         close_out();
      end
      while (rsp[1].seek_end_n === 1'b0 && low < bound) begin
         cyc(1);
         low++;
      end
      chk(low, TRIED);
   endtask

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_reset();
      chk({rsp, irq, wait_rq}, 32'h089);
      rchk(dcs_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h0);
      rstat(32'hFFFFFFFF, 32'h0);
      rchk(dcs_pkg::REG_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0);
      wreg(dcs_pkg::REG_CTRL, 32'hFFFFFFFF);
      rchk(dcs_pkg::REG_CTRL, 32'hFFFFFFFF, 32'hF1F);
      wreg(8'h20, 32'hFFFFFFFF);
      rchk(8'h20, 32'hFFFFFFFF, 32'h0);
      rchk(dcs_pkg::REG_IRQ_CLEAR, 32'hFFFFFFFF, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_select();
      wreg(dcs_pkg::REG_CTRL, 32'h005);
      wreg(dcs_pkg::REG_IRQ_ENABLE, 32'h01);
      c0_u.sel(4'h6, 1'b0);
      cyc(3);
      chk(rsp[0].unit_selected, 32'h0);
      c0_u.drop();
      c0_u.sel(4'h5, 1'b0);
      cyc(3);
      chk({rsp[0].unit_selected, rsp[0].busy}, 32'h2);
      cyc(80);
      chk(rsp[0].port_enable, 32'h1);
      rstat(32'h0F, 32'h05);
      chk(irq, 32'h1);
      wreg(dcs_pkg::REG_IRQ_CLEAR, 32'h3F);
      cyc(2);
      chk(irq, 32'h0);
      $display("test select done");
   endtask

   task automatic t_refuse();
      c1_u.sel(4'h5, 1'b0);
      cyc(3);
      chk({rsp[1].unit_selected, rsp[1].busy}, 32'h3);
      cyc(60);
      chk(rsp[1].port_enable, 32'h0);
      rstat(32'hCF, 32'h85);
      rchk(dcs_pkg::REG_IRQ_STATUS, 32'h3F, 32'h08);
      chk(irq, 32'h0);
      c1_u.drop();
      c0_u.drop();
      cyc(3);
      chk(rsp[0].unit_selected, 32'h0);
      cyc(60);
      chk(rsp[0].port_enable, 32'h0);
      rstat(32'h0F, 32'h04);
      c1_u.sel(4'h5, 1'b0);
      cyc(3);
      chk(rsp[1].busy, 32'h1);
      c1_u.drop();
      c0_u.sel(4'h5, 1'b0);
      cyc(60);
      chk(rsp[0].port_enable, 32'h1);
      $display("test refuse done");
   endtask

   task automatic t_timeout();
      c0_u.drop();
      cyc(100);
      rstat(32'h0C, 32'h04);
      seek_pulse(400);
      rstat(32'hCF, 32'h00);
      $display("test timeout done");
   endtask

   task automatic t_absolute();
      wreg(dcs_pkg::REG_CTRL, 32'h015);
      c0_u.sel(4'h5, 1'b0);
      cyc(80);
      c0_u.drop();
      cyc(RELEASE + 100);
      rstat(32'h0F, 32'h04);
      c0_u.sel(4'h5, 1'b0);
      cyc(80);
      c0_u.rel();
      cyc(2);
      rstat(32'h0F, 32'h01);
      c1_u.sel(4'h5, 1'b0);
      cyc(3);
      chk(rsp[1].busy, 32'h1);
      c1_u.drop();
      c0_u.drop();
      cyc(60);
      c1_u.sel(4'h5, 1'b0);
      cyc(80);
      rstat(32'h0F, 32'h0A);
      $display("test absolute done");
   endtask

   task automatic t_priority();
      c0_u.sel(4'h5, 1'b1);
      cyc(80);
      rstat(32'h3F, 32'h25);
      chk({rsp[1].unit_selected, rsp[1].busy}, 32'h0);
      c1_u.drop();
      c1_u.sel(4'h5, 1'b0);
      cyc(60);
      chk({rsp[1].unit_selected, rsp[1].port_enable}, 32'h0);
      c1_u.drop();
      c0_u.rel();
      cyc(2);
      rstat(32'h3F, 32'h01);
      c0_u.drop();
      $display("test priority done");
   endtask

   task automatic t_maint();
      wreg(dcs_pkg::REG_CTRL, 32'hC05);
      c1_u.sel(4'h5, 1'b0);
      cyc(60);
      chk({rsp[1].unit_selected, rsp[1].busy}, 32'h0);
      rstat(32'h30A, 32'h200);
      c1_u.drop();
      wreg(dcs_pkg::REG_CTRL, 32'h405);
      c1_u.sel(4'h5, 1'b0);
      cyc(60);
      chk({rsp[1].unit_selected, rsp[1].port_enable}, 32'h3);
      c1_u.drop();
      $display("test maint done");
   endtask

   initial begin
      i_reset = 1'b1;
      adr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wd = 32'h0;
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      cyc(1);
      t_reset();
      t_select();
      t_refuse();
      t_timeout();
      t_absolute();
      t_priority();
      t_maint();
      close_out();
   end
endmodule

`default_nettype wire
